// ===== hdl/dmb_defs.vh
// Constants for the data-move and bank-select execution block
// Overview of operation
// - Move copies 8-bit source into 5-bit destination
// - Working register or indirect allowed on both operands
// - Bank load writes literal into low nibble
// - Bank load opcode fixed upper byte, nibble ignored
// - Reduced variant: upper bank nibble reads zero
`ifndef DMB_DEFS_VH
`define DMB_DEFS_VH
// Opcode patterns
`define DMB_MOVE_OP3 3'h3
`define DMB_BANK_OP8 8'hb8
// Instruction field positions
`define DMB_OP3_MSB 15
`define DMB_OP3_LSB 13
`define DMB_OP8_MSB 15
`define DMB_OP8_LSB 8
`define DMB_DST_MSB 12
`define DMB_DST_LSB 8
`define DMB_SRC_MSB 7
`define DMB_SRC_LSB 0
`define DMB_LIT_MSB 3
`define DMB_LIT_LSB 0
// Special file addresses
`define DMB_ADDR_INDF0 8'h00
`define DMB_ADDR_INDF1 8'h08
`define DMB_ADDR_FSR0 8'h01
`define DMB_ADDR_FSR1 8'h09
`define DMB_ADDR_WORK 8'h0a
`define DMB_ADDR_BANK 8'h0f
// Reset values
`define DMB_BANK_RST 8'h00
`define DMB_WORK_RST 8'h00
`define DMB_PTR_RST 8'h00
// Quarter-cycle phases
`define DMB_Q1 2'h0
`define DMB_Q2 2'h1
`define DMB_Q3 2'h2
`define DMB_Q4 2'h3
`endif

// ===== hdl/dmb_file_mem.v
// Small data memory holding the general file locations
`timescale 1ns/1ps
module dmb_file_mem (
	// Clock
	input wire mclk,
	// Read port
	input wire [7:0] rd_addr,
	output reg [7:0] rd_data,
	// Write port
	input wire wr_en,
	input wire [7:0] wr_addr,
	input wire [7:0] wr_data
);
	reg [7:0] mem [0:255];

	// Registered read, write-first not needed: read and write in different phases
	always @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// ===== hdl/dmb_core.v
// Execution block for the file-to-peripheral move and bank-load instructions
`timescale 1ns/1ps
`include "dmb_defs.vh"
module dmb_core #(
	parameter REDUCED = 1'b0
) (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Instruction issue from the pipeline
	input wire instr_valid,
	input wire [15:0] instr_word,
	output wire instr_ready,
	// Completion
	output reg done_ff,
	output reg [7:0] working_reg_ff,
	output wire [7:0] bank_select_reg,
	output reg [7:0] fsr0_ff,
	output reg [7:0] fsr1_ff,
	// Status flags are never touched
	output wire status_we
);
	localparam ST_IDLE = `DMB_Q1;
	localparam ST_READ = `DMB_Q2;
	localparam ST_EXEC = `DMB_Q3;
	localparam ST_WRITE = `DMB_Q4;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg is_move_ff;
	reg [7:0] src_ff;
	reg [7:0] dst_ff;
	reg [3:0] lit_ff;
	reg [7:0] bank_ff;
	reg [7:0] data_ff;
	reg [7:0] src_eff;
	reg [7:0] dst_eff;
	reg [7:0] special_rdata;
	reg [7:0] nxt_data;
	reg [7:0] nxt_working;
	reg [7:0] nxt_bank;
	reg [7:0] nxt_fsr0;
	reg [7:0] nxt_fsr1;
	wire [7:0] mem_rdata;
	wire mem_we;
	wire is_move;
	wire is_bank;

	// Indirect slots resolve through their pointer registers
	function [7:0] dmb_resolve;
		input [7:0] a;
		input [7:0] p0;
		input [7:0] p1;
		begin
			if (a == `DMB_ADDR_INDF0) begin
				dmb_resolve = p0;
			end else if (a == `DMB_ADDR_INDF1) begin
				dmb_resolve = p1;
			end else begin
				dmb_resolve = a;
			end
		end
	endfunction

	// Addresses held in flip-flops rather than in the memory
	function dmb_is_special;
		input [7:0] a;
		begin
			dmb_is_special = (a == `DMB_ADDR_WORK) || (a == `DMB_ADDR_BANK)
				|| (a == `DMB_ADDR_FSR0) || (a == `DMB_ADDR_FSR1);
		end
	endfunction

	// Decode: move has 011 on top, bank load a fixed upper byte
	assign is_move = (instr_word[`DMB_OP3_MSB:`DMB_OP3_LSB] == `DMB_MOVE_OP3);
	assign is_bank = (instr_word[`DMB_OP8_MSB:`DMB_OP8_LSB] == `DMB_BANK_OP8);
	assign instr_ready = (state_ff == ST_IDLE);
	assign status_we = 1'b0;
	// Reduced variant has only the low nibble physically
	assign bank_select_reg = REDUCED ? {4'h0, bank_ff[3:0]} : bank_ff;

	// Phase sequencer, one instruction cycle of four quarters
	always @* begin
		case (state_ff)
			ST_IDLE: begin
				nxt_state = (instr_valid && (is_move || is_bank)) ? ST_READ : ST_IDLE;
			end
			ST_READ: begin
				nxt_state = ST_EXEC;
			end
			ST_EXEC: begin
				nxt_state = ST_WRITE;
			end
			ST_WRITE: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Effective addresses, both operands may be indirect
	always @* begin
		src_eff = dmb_resolve(src_ff, fsr0_ff, fsr1_ff);
		dst_eff = dmb_resolve(dst_ff, fsr0_ff, fsr1_ff);
	end

	// Memory write only for ordinary destinations in the write quarter
	assign mem_we = (state_ff == ST_WRITE) && is_move_ff && !dmb_is_special(dst_eff);

	dmb_file_mem u_mem (
		.mclk(mclk),
		.rd_addr(src_eff),
		.rd_data(mem_rdata),
		.wr_en(mem_we),
		.wr_addr(dst_eff),
		.wr_data(data_ff)
	);

	// Special registers bypass the memory on the read side
	always @* begin
		case (src_eff)
			`DMB_ADDR_WORK: special_rdata = working_reg_ff;
			`DMB_ADDR_BANK: special_rdata = bank_select_reg;
			`DMB_ADDR_FSR0: special_rdata = fsr0_ff;
			`DMB_ADDR_FSR1: special_rdata = fsr1_ff;
			default: special_rdata = 8'h00;
		endcase
	end

	// Source captured at the end of the execute quarter, memory data is one clock late
	always @* begin
		if (state_ff == ST_EXEC) begin
			nxt_data = dmb_is_special(src_eff) ? special_rdata : mem_rdata;
		end else begin
			nxt_data = data_ff;
		end
	end

	// Write quarter decode; every target keeps its value unless addressed
	always @* begin
		nxt_working = working_reg_ff;
		nxt_bank = bank_ff;
		nxt_fsr0 = fsr0_ff;
		nxt_fsr1 = fsr1_ff;
		if (state_ff == ST_WRITE) begin
			if (is_move_ff) begin
				case (dst_eff)
					`DMB_ADDR_WORK: nxt_working = data_ff;
					`DMB_ADDR_BANK: nxt_bank = data_ff;
					`DMB_ADDR_FSR0: nxt_fsr0 = data_ff;
					`DMB_ADDR_FSR1: nxt_fsr1 = data_ff;
					default: nxt_working = working_reg_ff;
				endcase
			end else begin
				nxt_bank = {bank_ff[7:4], lit_ff};
			end
		end
	end

	// Sequencer and the one-clock completion pulse
	always @(posedge mclk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			done_ff <= (state_ff == ST_WRITE);
		end
	end

	// Operands latched only on a taken word, so ignored opcodes leave no trace
	always @(posedge mclk) begin
		if (rst) begin
			is_move_ff <= 1'b0;
			src_ff <= 8'h00;
			dst_ff <= 8'h00;
			lit_ff <= 4'h0;
		end else if (instr_ready && instr_valid && (is_move || is_bank)) begin
			is_move_ff <= is_move;
			src_ff <= instr_word[`DMB_SRC_MSB:`DMB_SRC_LSB];
			dst_ff <= {3'h0, instr_word[`DMB_DST_MSB:`DMB_DST_LSB]};
			lit_ff <= instr_word[`DMB_LIT_MSB:`DMB_LIT_LSB];
		end
	end

	// Byte in flight between read and write quarters
	always @(posedge mclk) begin
		if (rst) begin
			data_ff <= 8'h00;
		end else begin
			data_ff <= nxt_data;
		end
	end

	// Working register
	always @(posedge mclk) begin
		if (rst) begin
			working_reg_ff <= `DMB_WORK_RST;
		end else begin
			working_reg_ff <= nxt_working;
		end
	end

	// Bank register; the reduced variant keeps no storage above the low nibble
	always @(posedge mclk) begin
		if (rst) begin
			bank_ff <= `DMB_BANK_RST;
		end else begin
			bank_ff <= REDUCED ? {4'h0, nxt_bank[3:0]} : nxt_bank;
		end
	end

	// First indirect pointer
	always @(posedge mclk) begin
		if (rst) begin
			fsr0_ff <= `DMB_PTR_RST;
		end else begin
			fsr0_ff <= nxt_fsr0;
		end
	end

	// Second indirect pointer
	always @(posedge mclk) begin
		if (rst) begin
			fsr1_ff <= `DMB_PTR_RST;
		end else begin
			fsr1_ff <= nxt_fsr1;
		end
	end
endmodule

// ===== tb/dmb_core_props.sv
// Port checks for the data-move execution block
`timescale 1ns/1ps
module dmb_core_props #(parameter REDUCED = 1'b0) (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Issue and results
	input wire instr_valid,
	input wire [15:0] instr_word,
	input wire instr_ready,
	input wire done_ff,
	input wire [7:0] working_reg_ff,
	input wire [7:0] bank_select_reg,
	input wire [7:0] fsr0_ff,
	input wire [7:0] fsr1_ff,
	input wire status_we
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Accepted word of either kind
	sequence s_take; instr_valid && instr_ready && (instr_word[15:13] == 3'h3 || instr_word[15:8] == 8'hb8); endsequence
	sequence s_busy; !instr_ready [*3] ##1 done_ff; endsequence
	property p_lat; s_take |=> s_busy; endproperty
	a_lat: assert property (p_lat) else $error("late");
	property p_bank; s_take and instr_word[15:8] == 8'hb8 |-> ##4 bank_select_reg[3:0] == $past(instr_word[3:0], 4)
		&& bank_select_reg[7:4] == $past(bank_select_reg[7:4], 4); endproperty
	a_bank: assert property (p_bank) else $error("bank");
	property p_move_w; s_take and instr_word == 16'h6a0f |-> ##4 working_reg_ff == bank_select_reg; endproperty
	a_move_w: assert property (p_move_w) else $error("move");
	property p_fsr; s_take and instr_word == 16'h610a |-> ##4 fsr0_ff == $past(working_reg_ff, 4); endproperty
	a_fsr: assert property (p_fsr) else $error("fsr");
	property p_fsr1; s_take and instr_word == 16'h690a |-> ##4 fsr1_ff == $past(working_reg_ff, 4); endproperty
	a_fsr1: assert property (p_fsr1) else $error("second pointer");
	property p_flag; status_we == 1'b0; endproperty
	a_flag: assert property (p_flag) else $error("flags");
	property p_red; !REDUCED || bank_select_reg[7:4] == 4'h0; endproperty
	a_red: assert property (p_red) else $error("upper");
	property p_chg; $changed(working_reg_ff) |-> done_ff; endproperty
	a_chg: assert property (p_chg) else $error("stray");
	property p_pulse; done_ff |-> instr_ready ##1 !done_ff; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse");
endmodule
bind dmb_core dmb_core_props #(.REDUCED(REDUCED)) chk (.mclk, .rst, .instr_valid, .instr_word, .instr_ready,
	.done_ff, .working_reg_ff, .bank_select_reg, .fsr0_ff, .fsr1_ff, .status_we);

// ===== tb/dmb_issuer.sv
// Pipeline model offering words to the block
`timescale 1ns/1ps
module dmb_issuer (
	// Clock
	input wire mclk,
	// Issue handshake
	input wire instr_ready,
	output logic instr_valid,
	output logic [15:0] instr_word
);
	initial begin
		instr_valid = 1'b0;
		instr_word = 16'h0000;
	end
	// Hold to the taking edge; released lines never keep the old word
	task automatic issue(input logic [15:0] w);
		while (instr_ready !== 1'b1) #4;
		instr_valid = 1'b1;
		instr_word = w;
		#4;
		instr_valid = 1'b0;
		instr_word = ~w;
	endtask
endmodule

// ===== tb/tb_data_move_and_bank_select.sv
// Self-checking bench for the data-move block
`timescale 1ns/1ps
module tb_data_move_and_bank_select;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	wire v, rdy, done;
	wire [15:0] iw;
	wire [7:0] wr, bk;
	int failures = 0;
	int checks = 0;
	logic [15:0] q[$];
	logic [7:0] k;
	logic [7:0] w_exp;
	logic [15:0] nx;
	wire [7:0] wr_r, bk_r;
	always #2 mclk = ~mclk;
	dmb_issuer pipe (.mclk, .instr_ready(rdy), .instr_valid(v), .instr_word(iw));
	dmb_core uut (.mclk, .rst, .instr_valid(v), .instr_word(iw), .instr_ready(rdy), .done_ff(done),
		.working_reg_ff(wr), .bank_select_reg(bk), .fsr0_ff(), .fsr1_ff(), .status_we());
	// Reduced variant on the same issue stream; its upper nibble must read zero
	dmb_core #(.REDUCED(1'b1)) uut_red (.mclk, .rst, .instr_valid(v), .instr_word(iw), .instr_ready(), .done_ff(),
		.working_reg_ff(wr_r), .bank_select_reg(bk_r), .fsr0_ff(), .fsr1_ff(), .status_we());
	task automatic check(input string name, input logic [15:0] s, input logic [15:0] x);
		checks++;
		if (s !== x) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, x, s);
		end
	endtask
	task automatic give_verdict;
		if (failures == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Random idle gap models a slow pipeline
	task automatic run(input logic [15:0] w, input logic [15:0] x);
		repeat ($urandom_range(2)) #4;
		q.push_back(x);
		pipe.issue(w);
	endtask
	// Oldest note against each completion
	always @(posedge mclk) begin
		if (done === 1'b1) begin
			nx = q.pop_front();
			check("work_bank", {wr, bk}, nx);
			check("reduced_work_bank", {wr_r, bk_r}, nx);
		end
	end
	initial begin
		#4000;
		failures++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'h54b8));
		repeat (10) @(posedge mclk);
		#1 rst = 1'b0;
		run(16'hb80f, 16'h000f);
		run(16'h6a0f, 16'h0f0f);
		run(16'h610a, 16'h0f0f);
		run(16'h690a, 16'h0f0f);
		// Unknown opcode offered once; no completion may follow it
		pipe.issue(16'h2a0f);
		#4;
		w_exp = 8'h0f;
		// Both pointers aim at the bank register; location 15h is plain memory
		for (int i = 0; i < 6; i++) begin
			k = $urandom;
			run({8'hb8, k}, {w_exp, 4'h0, k[3:0]});
			w_exp = {4'h0, k[3:0]};
			run(16'h6a00, {w_exp, w_exp});
			run({8'hb8, ~k}, {w_exp, 4'h0, ~k[3:0]});
			run(16'h750a, {w_exp, 4'h0, ~k[3:0]});
			run(16'h6a0f, {4'h0, ~k[3:0], 4'h0, ~k[3:0]});
			run(16'h6a15, {w_exp, 4'h0, ~k[3:0]});
			run(i[0] ? 16'h680a : 16'h600a, {w_exp, w_exp});
		end
		for (int n = 0; n < 20 && q.size() > 0; n++) @(posedge mclk);
		check("notes_left", 16'(q.size()), 16'h0000);
		give_verdict();
	end
endmodule
